// ===== irq_ctrl_pkg.sv
// Purpose: Constants for the vectored priority interrupt controller.
// Assumes: AXI4-Lite register access, one register byte per aligned word.
// Notes:   Register offsets are word indices; byte address is four times the index.
//
// What this block does
// - Seventeen live sources, six external, eleven internal.
// - Software and watchdog traps are pseudo non-maskable.
// - Fixed vectors descend by four from top.
// - Lowest pending index wins the grant.
// - Maskable needs master enable and own enable.
// - External 0 also needs its pin gate.
// - Latches 2 to 17; none for software trap.
// - Request sets latch; acceptance clears it.
// - Reset clears every pending latch.
// - Latches sit in four byte registers.
// - Writing zero clears a latch, except latch 2.
// - Writing one never sets a latch.
// - Software can read the pending latches.
// - Acceptance clears the master enable flag.
// - Traps bypass enables but never nest.
// - Master enable is bit 0, resets zero.
// - Request held until accepted or cleared.

package irq_ctrl_pkg;

  localparam int          NUM_SLOTS       = 32;
  localparam int          FIRST_LIVE      = 3;
  localparam int          LAST_LIVE       = 17;
  localparam int          SLOT_SW_TRAP    = 1;
  localparam int          SLOT_WD_TRAP    = 2;
  localparam int          SLOT_EXT0       = 3;
  localparam int          IMF_BIT         = 0;
  localparam int          VEC_W           = 20;
  localparam int          ADDR_W          = 8;

  localparam logic [19:0] VECTOR_TOP      = 20'hF_FFFC;
  localparam logic [19:0] VECTOR_STEP     = 20'h0_0004;

  // Register word indices; byte address is index times four.
  localparam logic [5:0]  IDX_ENABLE_B2   = 6'h2C;
  localparam logic [5:0]  IDX_ENABLE_B3   = 6'h2D;
  localparam logic [5:0]  IDX_PENDING_B2  = 6'h2E;
  localparam logic [5:0]  IDX_PENDING_B3  = 6'h2F;
  localparam logic [5:0]  IDX_ENABLE_B0   = 6'h3A;
  localparam logic [5:0]  IDX_ENABLE_B1   = 6'h3B;
  localparam logic [5:0]  IDX_PENDING_B0  = 6'h3C;
  localparam logic [5:0]  IDX_PENDING_B1  = 6'h3D;

  localparam logic [31:0] PENDING_RESET   = 32'h0000_0000;
  localparam logic [31:0] ENABLE_RESET    = 32'h0000_0000;
  // Bits that exist in the enable and pending images; the rest read zero.
  localparam logic [31:0] ENABLE_MASK     = 32'hFFFF_FFF9;
  localparam logic [31:0] PENDING_MASK    = 32'hFFFF_FFFC;
  localparam logic [31:0] LIVE_MASK       = 32'h0003_FFFC;

  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

endpackage : irq_ctrl_pkg

// ===== vectored_priority_interrupt_controller.sv
// Purpose: Prioritised vectored interrupt controller with AXI4-Lite registers.
// Assumes: Sources and the CPU core run on aclk; requests are one-cycle pulses.
// Notes:   Grant and vector are registered, so they trail the latch state by one cycle.
`timescale 1ns/1ps
`default_nettype none

module vectored_priority_interrupt_controller
  import irq_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  // AXI4-Lite write address and data
  input  wire logic [irq_ctrl_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                           s_axi_awvalid,
  output var  logic                           s_axi_awready,
  input  wire logic [31:0]                    s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output var  logic                           s_axi_wready,
  // AXI4-Lite write response
  output var  logic [1:0]                     s_axi_bresp,
  output var  logic                           s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  // AXI4-Lite read
  input  wire logic [irq_ctrl_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                           s_axi_arvalid,
  output var  logic                           s_axi_arready,
  output var  logic [31:0]                    s_axi_rdata,
  output var  logic [1:0]                     s_axi_rresp,
  output var  logic                           s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  // Interrupt sources
  input  wire logic                           software_trap,
  input  wire logic                           watchdog_trap,
  input  wire logic [irq_ctrl_pkg::LAST_LIVE:irq_ctrl_pkg::FIRST_LIVE] source_req,
  input  wire logic                           ext0_pin_gate,
  // CPU core side
  input  wire logic                           irq_accept,
  input  wire logic                           irq_return,
  input  wire logic                           trap_return,
  output var  logic                           irq_request,
  output var  logic [4:0]                     irq_index,
  output var  logic [irq_ctrl_pkg::VEC_W-1:0]  irq_vector
);
  import irq_ctrl_pkg::*;

  logic [31:0] pending_latch;
  logic [31:0] source_enable_flag;
  logic        master_irq_enable;
  logic        in_trap;
  logic        imf_before_trap;
  logic [31:0] set_req;
  logic [31:0] eligible;
  logic [31:0] sw_clear;
  logic [31:0] accept_clear;
  logic [31:0] sw_enable_wr;
  logic [31:0] sw_enable_mask;
  logic        next_request;
  logic [4:0]  next_index;

  logic [ADDR_W-1:0] aw_addr;
  logic              aw_held;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              w_held;
  logic              do_write;
  logic [3:0]        wr_dec;
  logic [3:0]        rd_dec;
  logic [31:0]       rd_img;

  // Maps a word index to a byte lane of the 32-bit image, and which image.
  function automatic logic [3:0] decode(input logic [ADDR_W-1:0] addr);
    logic [5:0] idx;
    idx = addr[ADDR_W-1:2];
    case (idx)
      IDX_ENABLE_B0:  decode = 4'b1_000;
      IDX_ENABLE_B1:  decode = 4'b1_001;
      IDX_ENABLE_B2:  decode = 4'b1_010;
      IDX_ENABLE_B3:  decode = 4'b1_011;
      IDX_PENDING_B0: decode = 4'b1_100;
      IDX_PENDING_B1: decode = 4'b1_101;
      IDX_PENDING_B2: decode = 4'b1_110;
      IDX_PENDING_B3: decode = 4'b1_111;
      default:        decode = 4'b0_000;
    endcase
  endfunction : decode

  // Lowest set bit wins; index 0 is the highest priority.
  function automatic logic [4:0] first_set(input logic [31:0] v);
    first_set = 5'd0;
    for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 5'(i);
      end
    end
  endfunction : first_set

  // Hardware requests; slot 1 has no latch and slots 18 to 31 are tied off.
  always_comb begin
    set_req = 32'h0000_0000;
    set_req[SLOT_WD_TRAP] = watchdog_trap;
    set_req[LAST_LIVE:FIRST_LIVE] = source_req;
  end

  // Eligibility of each slot for grant.
  always_comb begin
    eligible = 32'h0000_0000;
    eligible[SLOT_SW_TRAP] = software_trap & ~in_trap;
    eligible[SLOT_WD_TRAP] = pending_latch[SLOT_WD_TRAP] & ~in_trap;
    eligible[SLOT_EXT0] = pending_latch[SLOT_EXT0] & master_irq_enable
                          & source_enable_flag[SLOT_EXT0] & ext0_pin_gate;
    for (int i = SLOT_EXT0 + 1; i < NUM_SLOTS; i++) begin
      eligible[i] = pending_latch[i] & master_irq_enable & source_enable_flag[i];
    end
  end

  assign next_request = |eligible;
  assign next_index   = first_set(eligible);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_request <= 1'b0;
      irq_index   <= 5'd0;
      irq_vector  <= VECTOR_TOP;
    end else begin
      irq_request <= next_request;
      irq_index   <= next_index;
      irq_vector  <= VECTOR_TOP - VECTOR_STEP * {15'h0000, next_index};
    end
  end

  // AXI write channel capture; address and data may arrive in either order.
  assign do_write = aw_held & w_held & ~s_axi_bvalid;
  assign wr_dec   = decode(aw_addr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      aw_addr       <= '0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_held & ~s_axi_awready;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held       <= 1'b0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= ~w_held & ~s_axi_wready;
      if (s_axi_wvalid & s_axi_wready) begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_dec[3] ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Only byte lane 0 carries register data; the other lanes are ignored.
  always_comb begin
    logic [3:0] d;
    d = decode(aw_addr);
    sw_clear       = 32'h0000_0000;
    sw_enable_wr   = 32'h0000_0000;
    sw_enable_mask = 32'h0000_0000;
    if (do_write & d[3] & w_strb[0]) begin
      if (d[2]) begin
        sw_clear[{d[1:0], 3'b000} +: 8] = ~w_data[7:0];
        sw_clear[SLOT_WD_TRAP] = 1'b0;
      end else begin
        sw_enable_mask[{d[1:0], 3'b000} +: 8] = 8'hFF;
        sw_enable_wr[{d[1:0], 3'b000} +: 8]   = w_data[7:0];
      end
    end
  end

  always_comb begin
    accept_clear = 32'h0000_0000;
    if (irq_accept & irq_request) begin
      accept_clear[irq_index] = 1'b1;
    end
  end

  // A request arriving in the cycle of a clear wins, so no event is lost.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pending_latch <= PENDING_RESET;
    end else begin
      pending_latch <= ((pending_latch & ~sw_clear & ~accept_clear) | set_req)
                       & LIVE_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      source_enable_flag <= ENABLE_RESET;
    end else begin
      source_enable_flag <= ((source_enable_flag & ~sw_enable_mask)
                             | (sw_enable_wr & sw_enable_mask)) & ENABLE_MASK;
    end
  end

  // Acceptance beats a software write and the return instructions.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      master_irq_enable <= 1'b0;
    end else if (irq_accept & irq_request) begin
      master_irq_enable <= 1'b0;
    end else if (trap_return & in_trap) begin
      master_irq_enable <= imf_before_trap;
    end else if (irq_return) begin
      master_irq_enable <= 1'b1;
    end else if (sw_enable_mask[IMF_BIT]) begin
      master_irq_enable <= sw_enable_wr[IMF_BIT];
    end
  end

  // A trap in service blocks a second trap until its return.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_trap         <= 1'b0;
      imf_before_trap <= 1'b0;
    end else if (irq_accept & irq_request
                 & (irq_index == 5'(SLOT_SW_TRAP) | irq_index == 5'(SLOT_WD_TRAP))) begin
      in_trap         <= 1'b1;
      imf_before_trap <= master_irq_enable;
    end else if (trap_return) begin
      in_trap <= 1'b0;
    end
  end

  assign rd_dec = decode(s_axi_araddr);
  assign rd_img = rd_dec[2] ? pending_latch : {source_enable_flag[31:1], master_irq_enable};

  // AXI read channel; one read at a time.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= rd_dec[3] ? RESP_OKAY : RESP_SLVERR;
        s_axi_rdata   <= rd_dec[3] ? {24'h00_0000, rd_img[{rd_dec[1:0], 3'b000} +: 8]}
                                   : 32'h0000_0000;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : vectored_priority_interrupt_controller

`default_nettype wire

// ===== irq_ctrl_monitor.sv
// Purpose: Port assertions for the interrupt controller.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Grant outputs lag the latches by one cycle.
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_monitor
  import irq_ctrl_pkg::*;
(
  // Clock, reset and bus
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // Interrupt side
  input wire logic        ext0_pin_gate,
  input wire logic        irq_accept,
  input wire logic        irq_request,
  input wire logic [4:0]  irq_index,
  input wire logic [irq_ctrl_pkg::VEC_W-1:0] irq_vector
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_taken;
    irq_accept && irq_request && irq_index > 5'h02;
  endsequence
  sequence s_read;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_vector_map: assert property (irq_vector == VECTOR_TOP - VECTOR_STEP * 20'(irq_index))
    else $error("bad vector");
  a_reset_clear: assert property (disable iff (1'b0) !aresetn |=> !irq_request)
    else $error("grant after reset");
  a_no_reserved: assert property (irq_request |-> irq_index inside {[5'h01:5'h11]})
    else $error("reserved slot granted");
  a_idle_zero: assert property (!irq_request |-> irq_index == 5'h00)
    else $error("index without request");
  a_accept_masks: assert property (s_taken |-> ##2 (!irq_request || irq_index < 5'h03))
    else $error("maskable grant after accept");
  a_ext0_gate: assert property (irq_request && irq_index == 5'h03 |-> $past(ext0_pin_gate))
    else $error("ext0 granted with gate low");
  a_read_answer: assert property (s_read |=> s_axi_rvalid)
    else $error("read answer late");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
endmodule : irq_ctrl_monitor
`default_nettype wire

// ===== cpu_core_model.sv
// Purpose: CPU core model that accepts grants and returns after service.
// Assumes: Accepts only while a request is shown.
// Notes:   Fixed service time, long enough to probe trap nesting.
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Grant side
  input  wire logic       go,
  input  wire logic       irq_request,
  input  wire logic [4:0] irq_index,
  output var  logic       irq_accept,
  output var  logic       irq_return,
  output var  logic       trap_return
);
  logic [2:0] gap;
  logic       trap;
  always_ff @(posedge aclk) begin
    irq_accept  <= 1'b0;
    irq_return  <= 1'b0;
    trap_return <= 1'b0;
    if (!aresetn) begin
      gap  <= 3'h0;
      trap <= 1'b0;
    end else if (gap != 3'h0) begin
      gap         <= gap - 3'h1;
      irq_return  <= gap == 3'h1 && !trap;
      trap_return <= gap == 3'h1 && trap;
    end else if (go && irq_request) begin
      irq_accept <= 1'b1;
      trap       <= irq_index < 5'h03;
      gap        <= 3'h6;
    end
  end
endmodule : cpu_core_model
`default_nettype wire

// ===== vectored_priority_interrupt_controller_bench.sv
// Purpose: Self-checking bench for the interrupt controller.
// Assumes: A CPU model accepts grants and returns after a fixed service.
// Notes:   Drivers queue expectations; one watcher compares them.
`timescale 1ns/1ps
`default_nettype none
module vectored_priority_interrupt_controller_bench;
  import irq_ctrl_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, go = 1'b0, ext0_pin_gate = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic software_trap = 1'b0, watchdog_trap = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic irq_accept, irq_return, trap_return, irq_request;
  logic [1:0] s_axi_bresp, s_axi_rresp, q_wr[$];
  logic [17:3] source_req = 15'h0000;
  logic [4:0] irq_index, q_irq[$];
  logic [19:0] irq_vector;
  logic [33:0] q_rd[$];
  logic [17:0] mask;
  int error_cnt = 0, checked = 0, cycles = 0;
  vectored_priority_interrupt_controller u_vectored_priority_interrupt_controller (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'h1), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .software_trap, .watchdog_trap,
    .source_req, .ext0_pin_gate, .irq_accept, .irq_return, .trap_return,
    .irq_request, .irq_index, .irq_vector);
  cpu_core_model u_cpu_core_model (.aclk, .aresetn, .go, .irq_request, .irq_index,
    .irq_accept, .irq_return, .trap_return);
  always #2.5 aclk = ~aclk;
  task automatic check(input logic ok, input string what);
    checked++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask : check
  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  task automatic axi_wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] r);
    q_wr.push_back(r);
    s_axi_awaddr  <= {idx, 2'b00};
    s_axi_wdata   <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    // Ready stands before the answer, so the response is taken at its first edge.
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] r);
    q_rd.push_back({24'h00_0000, d, r});
    s_axi_araddr  <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  task automatic pulse(input logic [17:3] m);
    source_req <= m;
    @(posedge aclk);
    source_req <= 15'h0000;
  endtask : pulse
  task automatic wd_pulse;
    watchdog_trap <= 1'b1;
    @(posedge aclk);
    watchdog_trap <= 1'b0;
  endtask : wd_pulse
  task automatic drain;
    repeat (300) if (q_irq.size() != 0) @(posedge aclk);
    repeat (8) @(posedge aclk);
    check(q_irq.size() == 0, "grant missing");
  endtask : drain
  always @(posedge aclk) begin
    cycles++;
    if (s_axi_rvalid && s_axi_rready)
      check(q_rd.size() != 0 && {s_axi_rdata, s_axi_rresp} === q_rd.pop_front(), "read");
    if (s_axi_bvalid && s_axi_bready)
      check(q_wr.size() != 0 && s_axi_bresp === q_wr.pop_front(), "write response");
    if (irq_accept && irq_request) begin
      check(q_irq.size() != 0 && irq_index === q_irq[0] &&
            irq_vector === VECTOR_TOP - VECTOR_STEP * 20'(q_irq[0]), "grant");
      if (q_irq.size() != 0) void'(q_irq.pop_front());
    end
    if (cycles == 20000) begin
      check(1'b0, "timeout");
      conclude();
    end
  end
  initial begin
    void'($urandom(10));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 2; i++) begin
      axi_rd(IDX_PENDING_B0 + 6'(i), 8'h00, RESP_OKAY);
      axi_rd(IDX_PENDING_B2 + 6'(i), 8'h00, RESP_OKAY);
    end
    axi_rd(IDX_ENABLE_B0, 8'h00, RESP_OKAY);
    axi_rd(6'h01, 8'h00, RESP_SLVERR);
    axi_wr(6'h01, 8'hFF, RESP_SLVERR);
    $display("Test reset done");
    go <= 1'b1;
    mask = 18'($urandom) | 18'h2_0010;
    mask[3:0] = 4'h0;
    axi_wr(IDX_ENABLE_B0, 8'hF0, RESP_OKAY);
    axi_wr(IDX_ENABLE_B1, 8'hFF, RESP_OKAY);
    axi_wr(IDX_ENABLE_B2, 8'h03, RESP_OKAY);
    pulse(mask[17:3]);
    axi_rd(IDX_PENDING_B0, mask[7:0], RESP_OKAY);
    axi_rd(IDX_PENDING_B1, mask[15:8], RESP_OKAY);
    axi_rd(IDX_PENDING_B2, {6'h00, mask[17:16]}, RESP_OKAY);
    for (int i = 4; i < 18; i++) if (mask[i]) q_irq.push_back(5'(i));
    axi_wr(IDX_ENABLE_B0, 8'hF1, RESP_OKAY);
    drain();
    axi_rd(IDX_PENDING_B0, 8'h00, RESP_OKAY);
    axi_rd(IDX_ENABLE_B0, 8'hF1, RESP_OKAY);
    $display("Test priority done");
    axi_wr(IDX_ENABLE_B0, 8'h08, RESP_OKAY);
    axi_wr(IDX_ENABLE_B1, 8'h00, RESP_OKAY);
    pulse(15'h0101);
    axi_wr(IDX_ENABLE_B0, 8'h09, RESP_OKAY);
    repeat (4) @(posedge aclk);
    check(irq_request === 1'b0, "gated grant");
    q_irq.push_back(5'h03);
    ext0_pin_gate <= 1'b1;
    drain();
    axi_wr(IDX_ENABLE_B0, 8'h00, RESP_OKAY);
    axi_wr(IDX_PENDING_B1, 8'hFF, RESP_OKAY);
    axi_rd(IDX_PENDING_B1, 8'h08, RESP_OKAY);
    axi_wr(IDX_PENDING_B1, 8'hF7, RESP_OKAY);
    axi_rd(IDX_PENDING_B1, 8'h00, RESP_OKAY);
    $display("Test masking done");
    go <= 1'b0;
    wd_pulse();
    axi_wr(IDX_PENDING_B0, 8'h00, RESP_OKAY);
    axi_rd(IDX_PENDING_B0, 8'h04, RESP_OKAY);
    q_irq.push_back(5'h02);
    go <= 1'b1;
    drain();
    q_irq.push_back(5'h01);
    q_irq.push_back(5'h02);
    software_trap <= 1'b1;
    repeat (50) if (irq_accept !== 1'b1) @(posedge aclk);
    software_trap <= 1'b0;
    wd_pulse();
    repeat (2) @(posedge aclk);
    check(irq_request === 1'b0, "trap nested");
    drain();
    $display("Test traps done");
    conclude();
  end
endmodule : vectored_priority_interrupt_controller_bench
bind vectored_priority_interrupt_controller irq_ctrl_monitor u_irq_ctrl_monitor (
  .aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .ext0_pin_gate, .irq_accept, .irq_request,
  .irq_index, .irq_vector);
`default_nettype wire
